// file: verilog/acc_top.v
// Channel-enable and result-compare block of an 8-input, 12-bit converter.
// Assumes conversion results arrive as one-cycle strobes on aclk and that
// the converter sequencer honours the channel-enable outputs.
// Assumes a bus master that keeps to the AXI4-Lite handshake rules and
// uses aligned word addresses.
// Register map, byte offsets
//   0x24 channel enable: [9:8] input 7 source, [7:0] enables
//   0x28 unit 0 and 0x2C unit 1 compare, same layout:
//     [27:16] threshold, [11:8] match target, [5:3] channel,
//     [2] condition, [1] unit irq enable, [0] unit enable
//   0x30 mode: [1] two's complement, [0] differential
//   0x34 status, read only: [1:0] sticky hit flags
//   0x38 clear, write only: a 1 drops that flag, reads zero
//   0x3C irq enable: [1:0] one bit per unit
//
// Timing, in aclk edges
//   A write lands one edge after bvalid rises; outputs one later.
//   A read answers two edges after its address is taken.
//   A completing result shows as flag and irq two edges later.
//   A hit in the cycle of a clear keeps the flag set.
//   Results may come on every cycle; other channels are skipped.
//
// Limits
//   Differential pairing itself is the sequencer's job.
//   Reserved input-7 codes are stored and passed on.
//   The match counter restarts at zero after each hit.
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_top #(
  parameter ADDR_W = 8,
  parameter DATA_W = 12,
  parameter CNT_W  = 4
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,

  // Write address channel
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output wire              awready,

  // Write data channel
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output wire              wready,

  // Write response channel
  output wire [1:0]        bresp,
  output wire              bvalid,
  input  wire              bready,

  // Read address channel
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output wire              arready,

  // Read data channel
  output wire [31:0]       rdata,
  output wire [1:0]        rresp,
  output wire              rvalid,
  input  wire              rready,

  // Conversion results from the sequencer
  input  wire              result_valid,
  input  wire [2:0]        result_channel,
  input  wire [DATA_W-1:0] result_data,

  // Controls toward the converter
  output reg  [7:0]        channel_conversion_enable_q,
  output reg  [1:0]        input7_source_select_q,
  output reg               differential_mode_enable_q,
  output reg               result_format_select_q,

  // Flags and interrupt
  output reg  [1:0]        compare_hit_flags_q,
  output reg               irq_q
);

  // Register storage
  reg  [31:0]       chan_enable_q;
  reg  [31:0]       compare_q [0:1];
  reg  [31:0]       mode_q;
  reg  [31:0]       irq_enable_q;
  reg  [31:0]       rd_data_d;
  reg  [1:0]        flags_d;

  // Bus front end strobes
  wire [ADDR_W-1:0] rd_addr;
  wire              wr_en;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0]       wr_data;
  wire [3:0]        wr_strb;

  // Compare side
  wire [1:0]        unit_hit;
  wire [1:0]        unit_irq_en;
  wire [1:0]        clear_req;
  wire              res_accept;

  // Applies byte lanes to a register and keeps reserved bits at zero;
  // a lane whose strobe is low keeps its old byte
  function [31:0] merge_write;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    input [31:0] mask;
    reg   [31:0] lanes;
    begin
      lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge_write = ((old_val & ~lanes) | (new_val & lanes)) & mask;
    end
  endfunction

  // AXI4-Lite slave front end
  acc_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .aclk      (aclk),
    .aresetn   (aresetn),
    // Write request
    .awaddr    (awaddr),
    .awvalid   (awvalid),
    .awready_q (awready),
    .wdata     (wdata),
    .wstrb     (wstrb),
    .wvalid    (wvalid),
    .wready_q  (wready),

    // Write response
    .bresp_q   (bresp),
    .bvalid_q  (bvalid),
    .bready    (bready),

    // Read request
    .araddr    (araddr),
    .arvalid   (arvalid),
    .arready_q (arready),

    // Read answer
    .rdata_q   (rdata),
    .rresp_q   (rresp),
    .rvalid_q  (rvalid),
    .rready    (rready),

    // Register side
    .rd_data   (rd_data_d),
    .rd_addr_q (rd_addr),
    .wr_en_q   (wr_en),
    .wr_addr_q (wr_addr),
    .wr_data_q (wr_data),
    .wr_strb_q (wr_strb)
  );

  // Configuration registers; masks drop writes to reserved bits.
  // Status and clear hold no storage here, and an unmapped word is
  // refused by the front end before it reaches this decode.
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan_enable_q <= `ACC_CHAN_ENABLE_RST;
      compare_q[0]  <= `ACC_COMPARE_RST;
      compare_q[1]  <= `ACC_COMPARE_RST;
      mode_q        <= `ACC_MODE_RST;
      irq_enable_q  <= `ACC_IRQ_RST;
    end else if (wr_en) begin
      case (wr_addr)
        `ACC_OFS_CHAN_ENABLE: begin
          chan_enable_q <= merge_write(chan_enable_q, wr_data, wr_strb,
                                       `ACC_CHAN_ENABLE_MASK);
        end
        `ACC_OFS_COMPARE_0: begin
          compare_q[0] <= merge_write(compare_q[0], wr_data, wr_strb,
                                      `ACC_COMPARE_MASK);
        end
        `ACC_OFS_COMPARE_1: begin
          compare_q[1] <= merge_write(compare_q[1], wr_data, wr_strb,
                                      `ACC_COMPARE_MASK);
        end
        // Own mode word: differential inputs and result format
        `ACC_OFS_MODE: begin
          mode_q <= merge_write(mode_q, wr_data, wr_strb, `ACC_MODE_MASK);
        end
        // Second interrupt gate, one bit per unit
        `ACC_OFS_IRQ_ENABLE: begin
          irq_enable_q <= merge_write(irq_enable_q, wr_data, wr_strb, `ACC_IRQ_MASK);
        end
        // Status and clear need no storage
        default: begin
          chan_enable_q <= chan_enable_q;
        end
      endcase
    end
  end

  // A write of ones to the clear register releases the matching flags;
  // only lane 0 carries flag bits, so the other lanes are ignored
  assign clear_req = (wr_en && wr_addr == `ACC_OFS_IRQ_CLEAR && wr_strb[0]) ?
                     wr_data[1:0] : 2'h0;

  // Read mux; status shows live flags, the clear register reads zero.
  // The front end registers this word, so the mux may stay combinational.
  always @* begin
    case (rd_addr)
      `ACC_OFS_CHAN_ENABLE: rd_data_d = chan_enable_q;
      `ACC_OFS_COMPARE_0:   rd_data_d = compare_q[0];
      `ACC_OFS_COMPARE_1:   rd_data_d = compare_q[1];
      `ACC_OFS_MODE:        rd_data_d = mode_q;
      `ACC_OFS_IRQ_STATUS:  rd_data_d = {30'h0000_0000, compare_hit_flags_q};
      `ACC_OFS_IRQ_ENABLE:  rd_data_d = irq_enable_q;
      default:              rd_data_d = 32'h0000_0000;
    endcase
  end

  // Outputs toward the converter sequencer and analog front end.
  // Every control leaving the block is registered, so the sequencer
  // never sees a word that is half way through a write.
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_conversion_enable_q <= 8'h00;
      input7_source_select_q      <= `ACC_INPUT7_SOURCE_SELECT_PIN;
      differential_mode_enable_q  <= 1'b0;
      result_format_select_q      <= 1'b0;
    end else begin
      // Odd inputs are folded into their even partner in differential mode
      // (bits 1, 3, 5 and 7 are forced low while the mode bit is set)
      if (mode_q[`ACC_MODE_DIFF_BIT]) begin
        channel_conversion_enable_q <= chan_enable_q[`ACC_CHANNEL_ENABLE_BITS_MSB:`ACC_CHANNEL_ENABLE_BITS_LSB] &
                                       `ACC_EVEN_CHANNELS;
      end else begin
        channel_conversion_enable_q <= chan_enable_q[`ACC_CHANNEL_ENABLE_BITS_MSB:`ACC_CHANNEL_ENABLE_BITS_LSB];
      end
      input7_source_select_q     <= chan_enable_q[`ACC_INPUT7_SOURCE_SELECT_MSB:`ACC_INPUT7_SOURCE_SELECT_LSB];
      differential_mode_enable_q <= mode_q[`ACC_MODE_DIFF_BIT];
      result_format_select_q     <= mode_q[`ACC_MODE_FMT_BIT];
    end
  end

  // Results of inputs that are not taking part are ignored,
  // and so neither count nor break a run
  assign res_accept = result_valid & channel_conversion_enable_q[result_channel];

  // Two identical compare units;
  // both see the same result stream, each picks its own channel
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_unit
      assign unit_irq_en[gi] = compare_q[gi][`ACC_CMP_IE_BIT];
      acc_cmp_unit #(
        .DATA_W (DATA_W),
        .CNT_W  (CNT_W)
      ) u_cmp (
        .aclk           (aclk),
        .aresetn        (aresetn),
        // Fields of this unit's compare word
        .cmp_enable     (compare_q[gi][`ACC_CMP_EN_BIT]),
        .cmp_condition  (compare_q[gi][`ACC_CMP_COND_BIT]),
        .channel_select (compare_q[gi][`ACC_CMP_CH_MSB:`ACC_CMP_CH_LSB]),
        .match_target   (compare_q[gi][`ACC_CMP_CNT_MSB:`ACC_CMP_CNT_LSB]),
        .threshold      (compare_q[gi][`ACC_CMP_THR_MSB:`ACC_CMP_THR_LSB]),
        // Shared format and result stream
        .signed_mode    (result_format_select_q),
        .res_valid      (res_accept),
        .res_channel    (result_channel),
        .res_data       (result_data),
        .hit_q          (unit_hit[gi])
      );
    end
  endgenerate

  // Sticky flags: a hit in the cycle of a clear keeps the flag set
  // (set wins), so no hit is lost to a clear that races it
  always @* begin
    flags_d = (compare_hit_flags_q & ~clear_req) | unit_hit;
  end

  // Flag register and level interrupt.
  // The interrupt follows the next flag value, so it rises with the flag
  // and drops with the clear; both gates must be open to raise it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      compare_hit_flags_q <= 2'h0;
      irq_q               <= 1'b0;
    end else begin
      compare_hit_flags_q <= flags_d;
      irq_q <= |(flags_d & unit_irq_en & irq_enable_q[1:0]);
    end
  end

endmodule

// file: inc/acc_defs.vh
// Register map, field layout and reset values of the channel-enable
// and result-compare block.
// Assumes it is included by bare name from the design files.
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH

// Register byte offsets
`define ACC_OFS_CHAN_ENABLE   8'h24
`define ACC_OFS_COMPARE_0     8'h28
`define ACC_OFS_COMPARE_1     8'h2C
`define ACC_OFS_MODE          8'h30
`define ACC_OFS_IRQ_STATUS    8'h34
`define ACC_OFS_IRQ_CLEAR     8'h38
`define ACC_OFS_IRQ_ENABLE    8'h3C

// Channel-enable register fields
`define ACC_CHANNEL_ENABLE_BITS_MSB          7
`define ACC_CHANNEL_ENABLE_BITS_LSB          0
`define ACC_INPUT7_SOURCE_SELECT_MSB        9
`define ACC_INPUT7_SOURCE_SELECT_LSB        8
`define ACC_CHAN_ENABLE_MASK  32'h0000_03FF
`define ACC_CHAN_ENABLE_RST   32'h0000_0000
`define ACC_INPUT7_SOURCE_SELECT_PIN        2'h0
`define ACC_INPUT7_SOURCE_SELECT_BANDGAP    2'h1

// Compare register fields
`define ACC_CMP_EN_BIT        0
`define ACC_CMP_IE_BIT        1
`define ACC_CMP_COND_BIT      2
`define ACC_CMP_CH_MSB        5
`define ACC_CMP_CH_LSB        3
`define ACC_CMP_CNT_MSB       11
`define ACC_CMP_CNT_LSB       8
`define ACC_CMP_THR_MSB       27
`define ACC_CMP_THR_LSB       16
`define ACC_COMPARE_MASK      32'h0FFF_0F3F
`define ACC_COMPARE_RST       32'h0000_0000

// Mode register fields
`define ACC_MODE_DIFF_BIT     0
`define ACC_MODE_FMT_BIT      1
`define ACC_MODE_MASK         32'h0000_0003
`define ACC_MODE_RST          32'h0000_0000

// Interrupt status, clear and enable layout: one bit per compare unit
`define ACC_IRQ_MASK          32'h0000_0003
`define ACC_IRQ_RST           32'h0000_0000

// Differential mode keeps only the even inputs
`define ACC_EVEN_CHANNELS     8'h55

// Bus responses
`define ACC_RESP_OKAY         2'h0
`define ACC_RESP_SLVERR       2'h2

`endif

// file: verilog/acc_cmp_unit.v
// One result-compare unit: consecutive-match counter against a threshold.
// Assumes results arrive as one-cycle strobes synchronous to aclk.
`timescale 1ns/1ps
module acc_cmp_unit #(
  parameter DATA_W = 12,
  parameter CNT_W  = 4
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              cmp_enable,
  input  wire              cmp_condition,
  input  wire [2:0]        channel_select,
  input  wire [CNT_W-1:0]  match_target,
  input  wire [DATA_W-1:0] threshold,
  input  wire              signed_mode,
  input  wire              res_valid,
  input  wire [2:0]        res_channel,
  input  wire [DATA_W-1:0] res_data,
  output reg               hit_q
);

  reg  [CNT_W:0]  cnt_q;
  wire            sel;
  wire [DATA_W-1:0] res_key;
  wire [DATA_W-1:0] thr_key;
  wire            below;
  wire            match;
  wire [CNT_W:0]  cnt_inc;
  wire [CNT_W:0]  target_plus1;

  // Only results of the chosen channel are looked at
  assign sel = res_valid & (res_channel == channel_select);
  // Flipping the sign bit turns a two's-complement order into an unsigned one
  assign res_key = {res_data[DATA_W-1] ^ signed_mode, res_data[DATA_W-2:0]};
  assign thr_key = {threshold[DATA_W-1] ^ signed_mode, threshold[DATA_W-2:0]};
  assign below = res_key < thr_key;
  assign match = cmp_condition ? ~below : below;
  assign cnt_inc = cnt_q + {{CNT_W{1'b0}}, 1'b1};
  assign target_plus1 = {1'b0, match_target} + {{CNT_W{1'b0}}, 1'b1};

  // Counter and hit pulse; a hit restarts the run from zero
  always @(posedge aclk) begin
    if (!aresetn || !cmp_enable) begin
      cnt_q <= {(CNT_W+1){1'b0}};
      hit_q <= 1'b0;
    end else begin
      hit_q <= 1'b0;
      if (sel) begin
        if (match) begin
          if (cnt_inc == target_plus1) begin
            hit_q <= 1'b1;
            cnt_q <= {(CNT_W+1){1'b0}};
          end else begin
            cnt_q <= cnt_inc;
          end
        end else begin
          cnt_q <= {(CNT_W+1){1'b0}};
        end
      end
    end
  end

endmodule

// file: verilog/acc_axil_slave.v
// AXI4-Lite slave front end: takes bus requests and hands out one-cycle
// register write strobes and a held read address.
// Assumes the register read data returned on rd_data depends only on rd_addr.
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_axil_slave #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output reg               awready_q,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output reg               wready_q,
  output reg  [1:0]        bresp_q,
  output reg               bvalid_q,
  input  wire              bready,
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output reg               arready_q,
  output reg  [31:0]       rdata_q,
  output reg  [1:0]        rresp_q,
  output reg               rvalid_q,
  input  wire              rready,
  input  wire [31:0]       rd_data,
  output reg  [ADDR_W-1:0] rd_addr_q,
  output reg               wr_en_q,
  output reg  [ADDR_W-1:0] wr_addr_q,
  output reg  [31:0]       wr_data_q,
  output reg  [3:0]        wr_strb_q
);

  reg [ADDR_W-1:0] aw_addr_q;
  reg [31:0]       w_data_q;
  reg [3:0]        w_strb_q;
  reg              ar_pend_q;

  // Decodes whether an address hits a register word
  function addr_mapped;
    input [ADDR_W-1:0] a;
    begin
      case (a)
        `ACC_OFS_CHAN_ENABLE, `ACC_OFS_COMPARE_0, `ACC_OFS_COMPARE_1,
        `ACC_OFS_MODE, `ACC_OFS_IRQ_STATUS, `ACC_OFS_IRQ_CLEAR,
        `ACC_OFS_IRQ_ENABLE: addr_mapped = 1'b1;
        default: addr_mapped = 1'b0;
      endcase
    end
  endfunction

  // Write path: address and data held independently, committed together
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `ACC_RESP_OKAY;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      wr_en_q   <= 1'b0;
      wr_addr_q <= {ADDR_W{1'b0}};
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end else begin
      wr_en_q <= 1'b0;
      if (awvalid && awready_q) begin
        aw_addr_q <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready_q <= 1'b0;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
      if (!awready_q && !wready_q && !bvalid_q) begin
        bvalid_q  <= 1'b1;
        bresp_q   <= addr_mapped(aw_addr_q) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
        wr_en_q   <= addr_mapped(aw_addr_q);
        wr_addr_q <= aw_addr_q;
        wr_data_q <= w_data_q;
        wr_strb_q <= w_strb_q;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Read path: address held one cycle for the register mux, then answered
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      ar_pend_q <= 1'b0;
      rd_addr_q <= {ADDR_W{1'b0}};
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `ACC_RESP_OKAY;
    end else begin
      if (arvalid && arready_q) begin
        rd_addr_q <= araddr;
        arready_q <= 1'b0;
        ar_pend_q <= 1'b1;
      end
      if (ar_pend_q) begin
        ar_pend_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= addr_mapped(rd_addr_q) ? rd_data : 32'h0000_0000;
        rresp_q   <= addr_mapped(rd_addr_q) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end
      if (rvalid_q && rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

endmodule

// file: bench/acc_properties.sv
// Concurrent checks on the ports of the channel-enable and compare block.
// Assumes it is bound to acc_top and sees only that module's ports.
`timescale 1ns/1ps
module acc_checker (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic [1:0] bresp,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic [31:0] rdata,
  input wire logic       rvalid,
  input wire logic       rready,
  input wire logic       result_valid,
  input wire logic [7:0] channel_conversion_enable_q,
  input wire logic       differential_mode_enable_q,
  input wire logic [1:0] compare_hit_flags_q,
  input wire logic       irq_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Bus timing and holding of answers
  a_write_resp_late: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
    else $error("write response not given two cycles after the request");
  a_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before ready");
  a_read_latency: assert property (arvalid && arready |-> ##2 rvalid)
    else $error("read data not given two cycles after the address");
  a_read_busy: assert property (arvalid && arready |=> !arready)
    else $error("read address accepted while a read is open");
  a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before ready");

  // Flags, interrupt and enables
  a_flag0_cause: assert property ($rose(compare_hit_flags_q[0]) |-> $past(result_valid, 2))
    else $error("unit 0 flag rose without a result two cycles before");
  a_flag1_cause: assert property ($rose(compare_hit_flags_q[1]) |-> $past(result_valid, 2))
    else $error("unit 1 flag rose without a result two cycles before");
  a_flag_sticky: assert property ($fell(|compare_hit_flags_q) |-> $past(bvalid))
    else $error("flag fell without a register write");
  a_irq_cause: assert property ($rose(irq_q) |-> compare_hit_flags_q != 2'h0)
    else $error("interrupt rose with no flag set");
  a_diff_even_only: assert property (differential_mode_enable_q |->
    (channel_conversion_enable_q & 8'hAA) == 8'h00)
    else $error("odd input enabled in differential mode");
endmodule

bind acc_top acc_checker acc_checker_i (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .result_valid(result_valid), .channel_conversion_enable_q(channel_conversion_enable_q),
  .differential_mode_enable_q(differential_mode_enable_q),
  .compare_hit_flags_q(compare_hit_flags_q), .irq_q(irq_q)
);

// file: bench/acc_top_tb.sv
// Self-checking bench for the channel-enable and compare block.
// Assumes acc_top with default parameters and a 100 MHz clock.
`timescale 1ns/1ps
module acc_top_tb;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, result_valid;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb;
  reg  [2:0]  result_channel;
  reg  [11:0] result_data;
  wire        awready, wready, bvalid, arready, rvalid, diff_q, fmt_q, irq_q;
  wire [1:0]  bresp, rresp, flags_q, sel7_q;
  wire [31:0] rdata;
  wire [7:0]  channel_enable_bits_q;
  integer     n_fail, cmp_count;

  acc_top acc_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .result_valid(result_valid), .result_channel(result_channel), .result_data(result_data),
    .channel_conversion_enable_q(channel_enable_bits_q), .input7_source_select_q(sel7_q),
    .differential_mode_enable_q(diff_q), .result_format_select_q(fmt_q),
    .compare_hit_flags_q(flags_q), .irq_q(irq_q));

  // Clock of 10 ns
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  task chk_word(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
    end
  endtask

  task chk_bits(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: bits %h, wanted %h", $time, got, exp);
      end
    end
  endtask

  task hang;
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: no answer on the bus", $time);
      give_verdict;
    end
  endtask

  // Write one word; address and data offered together
  task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
    integer i;
    reg     done;
    begin
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
      for (i = 0; i < 50 && !done; i = i + 1) begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) begin
          bready <= 1'b0;
          done = 1'b1;
          chk_bits({6'h00, bresp}, {6'h00, er});
        end
      end
      if (!done) hang;
    end
  endtask

  // Read one word and compare data and response
  task axi_rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    integer i;
    reg     done;
    begin
      done = 1'b0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (i = 0; i < 50 && !done; i = i + 1) begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) begin
          rready <= 1'b0;
          done = 1'b1;
          chk_word(rdata, ed);
          chk_bits({6'h00, rresp}, {6'h00, er});
        end
      end
      if (!done) hang;
    end
  endtask

  // One-cycle conversion result
  task send_res(input [2:0] ch, input [11:0] d);
    begin
      @(posedge aclk);
      result_channel <= ch; result_data <= d; result_valid <= 1'b1;
      @(posedge aclk);
      result_valid <= 1'b0;
    end
  endtask

  task settle;
    repeat (3) @(posedge aclk);
  endtask

  // Main sequence
  initial begin
    n_fail = 0; cmp_count = 0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; result_valid = 1'b0; awaddr = 8'h00;
    araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'hF; result_channel = 3'h0;
    result_data = 12'h000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(8'h24, 32'h0000_0000, 2'h0);
    axi_rd(8'h28, 32'h0000_0000, 2'h0);
    axi_rd(8'h2C, 32'h0000_0000, 2'h0);
    axi_wr(8'h24, 32'hFFFF_FFFF, 2'h0);
    axi_rd(8'h24, 32'h0000_03FF, 2'h0);
    settle;
    chk_bits(channel_enable_bits_q, 8'hFF);
    chk_bits({6'h00, sel7_q}, 8'h03);
    axi_wr(8'h24, 32'h0000_01A5, 2'h0);
    axi_wr(8'h30, 32'h0000_0001, 2'h0);
    settle;
    chk_bits(channel_enable_bits_q, 8'h05);
    chk_bits({6'h00, sel7_q}, 8'h01);
    chk_bits({6'h00, fmt_q, diff_q}, 8'h01);
    axi_wr(8'h30, 32'h0000_0000, 2'h0);
    axi_wr(8'h24, 32'h0000_00FF, 2'h0);
    settle;
    chk_bits({6'h00, sel7_q}, 8'h00);
    wstrb <= 4'h1;
    axi_wr(8'h24, 32'h0000_03FF, 2'h0);
    wstrb <= 4'hF;
    axi_rd(8'h24, 32'h0000_00FF, 2'h0);
    axi_rd(8'h40, 32'h0000_0000, 2'h2);
    axi_wr(8'h40, 32'h0000_0001, 2'h2);
    axi_wr(8'h2C, 32'hFFFF_FFFE, 2'h0);
    axi_rd(8'h2C, 32'h0FFF_0F3E, 2'h0);
    axi_wr(8'h3C, 32'h0000_0003, 2'h0);
    // Unit 0: channel 5, at or above 0x800, three in a row
    axi_wr(8'h28, 32'h0800_022F, 2'h0);
    send_res(3'h5, 12'h900);
    send_res(3'h5, 12'h800);
    send_res(3'h5, 12'h7FF);
    send_res(3'h5, 12'h900);
    send_res(3'h5, 12'h800);
    send_res(3'h4, 12'hFFF);
    settle;
    chk_bits({6'h00, flags_q}, 8'h00);
    send_res(3'h5, 12'hFFF);
    settle;
    chk_bits({6'h00, flags_q}, 8'h01);
    chk_bits({7'h00, irq_q}, 8'h01);
    axi_rd(8'h34, 32'h0000_0001, 2'h0);
    axi_wr(8'h3C, 32'h0000_0000, 2'h0);
    settle;
    chk_bits({7'h00, irq_q}, 8'h00);
    axi_wr(8'h38, 32'h0000_0001, 2'h0);
    settle;
    chk_bits({6'h00, flags_q}, 8'h00);
    axi_rd(8'h38, 32'h0000_0000, 2'h0);
    axi_rd(8'h3C, 32'h0000_0000, 2'h0);
    // Unit 1: signed format, below -256 on channel 2
    axi_wr(8'h30, 32'h0000_0002, 2'h0);
    axi_rd(8'h30, 32'h0000_0002, 2'h0);
    axi_wr(8'h3C, 32'h0000_0003, 2'h0);
    axi_wr(8'h2C, 32'h0F00_0013, 2'h0);
    send_res(3'h2, 12'h7FF);
    settle;
    chk_bits({6'h00, flags_q}, 8'h00);
    chk_bits({6'h00, fmt_q, diff_q}, 8'h02);
    send_res(3'h2, 12'hE00);
    settle;
    chk_bits({6'h00, flags_q}, 8'h02);
    chk_bits({7'h00, irq_q}, 8'h01);
    axi_wr(8'h38, 32'h0000_0002, 2'h0);
    axi_wr(8'h30, 32'h0000_0000, 2'h0);
    send_res(3'h2, 12'h7FF);
    settle;
    chk_bits({6'h00, flags_q}, 8'h02);
    axi_wr(8'h38, 32'h0000_0002, 2'h0);
    axi_wr(8'h2C, 32'h0F00_0012, 2'h0);
    send_res(3'h2, 12'h7FF);
    settle;
    chk_bits({6'h00, flags_q}, 8'h00);
    // Unit 0: disabling mid-run drops the partial count
    axi_wr(8'h28, 32'h0800_012D, 2'h0);
    send_res(3'h5, 12'h900);
    axi_wr(8'h28, 32'h0800_012C, 2'h0);
    axi_wr(8'h28, 32'h0800_012D, 2'h0);
    send_res(3'h5, 12'h900);
    settle;
    chk_bits({6'h00, flags_q}, 8'h00);
    send_res(3'h5, 12'h900);
    settle;
    chk_bits({6'h00, flags_q}, 8'h01);
    chk_bits({7'h00, irq_q}, 8'h00);
    // A disabled input never reaches the compare units
    axi_wr(8'h38, 32'h0000_0001, 2'h0);
    axi_wr(8'h24, 32'h0000_00DF, 2'h0);
    axi_wr(8'h28, 32'h0800_002D, 2'h0);
    send_res(3'h5, 12'h900);
    settle;
    chk_bits({6'h00, flags_q}, 8'h00);
    give_verdict;
  end
endmodule
